// *** src/gpio_port.sv ***
// top of the 8-bit bidirectional pin port with apb register access
// assumes: apb master per protocol; pins asynchronous; one clock, sync reset
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module gpio_port #(
   parameter int WIDTH = 8                          // pins in the port [RULE1]
) (
   input  wire logic             ref_clk_i,         // 200 MHz system clock
   input  wire logic             srst_i,            // sync reset, high
   input  wire logic             psel_i,            // apb select
   input  wire logic             penable_i,         // apb enable
   input  wire logic             pwrite_i,          // apb direction
   input  wire logic [11:0]      paddr_i,           // apb byte address
   input  wire logic [31:0]      pwdata_i,          // apb write data
   input  wire logic [3:0]       pstrb_i,           // apb byte strobes
   output logic      [31:0]      prdata_o,          // apb read data
   output logic                  pready_o,          // apb ready
   output logic                  pslverr_o,         // apb error
   input  wire logic [WIDTH-1:0] pin_i,             // pin levels in
   output logic      [WIDTH-1:0] pin_o,             // pin drive value
   output logic      [WIDTH-1:0] pin_oe_n_o,        // low = pin driven
   output logic      [WIDTH-1:0] pullup_on_o        // weak pull-up enables
);
   // ==========================================================
   // register state
   logic [WIDTH-1:0] direction_reg, direction_next;   // direction bits
   logic [WIDTH-1:0] latch_reg, latch_next;           // output data latch
   logic [WIDTH-1:0] analog_reg, analog_next;         // analog select bits
   logic [WIDTH-1:0] pullup_reg, pullup_next;         // pull-up enable bits
   logic             pu_dis_reg, pu_dis_next;         // global pull-up disable
   logic [31:0]      rdata_reg, rdata_next;           // registered read data
   logic             err_reg, err_next;               // registered error
   gpio_port_pkg::apb_phase_t phase_reg, phase_next;  // slave phase

   logic [WIDTH-1:0] level;       // filtered pin levels
   logic [WIDTH-1:0] digital_rd;  // pin levels after analog gating
   logic [WIDTH-1:0] dir_view;    // direction as software sees it

   // ==========================================================
   // address decode used by both read and write paths
   function automatic logic addr_known(input logic [11:0] a);
      case (a)
         `PORT_OFS_PIN_LEVEL, `PORT_OFS_DIRECTION, `PORT_OFS_LATCH,
         `PORT_OFS_ANALOG_SEL, `PORT_OFS_PULLUP_EN, `PORT_OFS_OPTION: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction : addr_known

   // ==========================================================
   // pin input path
   pin_input_sync #(.WIDTH(WIDTH)) u_sync (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .pin_i     (pin_i),
      .level_o   (level)
   );

   // ==========================================================
   // pad control slices
   pin_pad_ctrl #(.WIDTH(WIDTH)) u_pad (
      .direction_i  (direction_reg),
      .latch_i      (latch_reg),
      .analog_i     (analog_reg),
      .pullup_en_i  (pullup_reg),
      .pu_disable_i (pu_dis_reg),
      .level_i      (level),
      .pad_out_o    (pin_o),
      .pad_oe_n_o   (pin_oe_n_o),
      .pullup_on_o  (pullup_on_o),
      .digital_rd_o (digital_rd)
   );

   // input-only pin always reads back as input
   always_comb begin
      dir_view = direction_reg;
      dir_view[`PORT_INPUT_ONLY_BIT] = 1'b1;  // [RULE3]
   end

   // ==========================================================
   // apb slave: one wait-free access phase, so pready stays high
   wire setup_ph  = psel_i & ~penable_i;
   wire access_ph = psel_i & penable_i;
   wire wr_fire   = access_ph & pwrite_i & addr_known(paddr_i);

   // next state of all registers
   always_comb begin
      direction_next = direction_reg;
      latch_next     = latch_reg;
      analog_next    = analog_reg;
      pullup_next    = pullup_reg;
      pu_dis_next    = pu_dis_reg;
      rdata_next     = rdata_reg;
      err_next       = err_reg;
      phase_next     = phase_reg;
      case (phase_reg)
         gpio_port_pkg::APB_IDLE: begin
            if (setup_ph) begin
               phase_next = gpio_port_pkg::APB_ACCESS;
               err_next   = ~addr_known(paddr_i);   // unmapped answers pslverr
               rdata_next = 32'h0000_0000;
               case (paddr_i)
                  `PORT_OFS_PIN_LEVEL:  rdata_next[WIDTH-1:0] = digital_rd;  // pins, not latch [RULE4] [RULE8]
                  `PORT_OFS_DIRECTION:  rdata_next[WIDTH-1:0] = dir_view;    // [RULE3]
                  `PORT_OFS_LATCH:      rdata_next[WIDTH-1:0] = latch_reg;   // latch itself [RULE15]
                  `PORT_OFS_ANALOG_SEL: rdata_next[WIDTH-1:0] = analog_reg;
                  `PORT_OFS_PULLUP_EN:  rdata_next[WIDTH-1:0] = pullup_reg;
                  `PORT_OFS_OPTION:     rdata_next[`PORT_OPT_PU_DIS_BIT] = pu_dis_reg;
                  default:              rdata_next = 32'h0000_0000;
               endcase
            end
         end
         gpio_port_pkg::APB_ACCESS: begin
            phase_next = gpio_port_pkg::APB_IDLE;
            if (wr_fire && pstrb_i[0]) begin
               case (paddr_i)
                  // merge pin reads into untouched bits, so analog outputs may get zeroed
                  `PORT_OFS_PIN_LEVEL:  latch_next = (digital_rd & ~pwdata_i[WIDTH-1:0])
                                                   | pwdata_i[WIDTH-1:0];  // [RULE4] [RULE5] [RULE10]
                  `PORT_OFS_DIRECTION:  direction_next = pwdata_i[WIDTH-1:0];
                  `PORT_OFS_LATCH:      latch_next = pwdata_i[WIDTH-1:0];
                  `PORT_OFS_ANALOG_SEL: analog_next = pwdata_i[WIDTH-1:0];
                  `PORT_OFS_PULLUP_EN:  pullup_next = pwdata_i[WIDTH-1:0];   // [RULE12]
                  `PORT_OFS_OPTION:     pu_dis_next = pwdata_i[`PORT_OPT_PU_DIS_BIT];
                  default:              latch_next = latch_reg;
               endcase
            end
         end
         default: phase_next = gpio_port_pkg::APB_IDLE;
      endcase
   end

   // register update
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         direction_reg <= `PORT_RST_DIRECTION;
         latch_reg     <= `PORT_RST_LATCH;
         analog_reg    <= `PORT_RST_ANALOG_SEL;
         pullup_reg    <= `PORT_RST_PULLUP_EN;
         pu_dis_reg    <= `PORT_RST_OPTION;      // pull-ups off after reset [RULE14]
         rdata_reg     <= 32'h0000_0000;
         err_reg       <= 1'b0;
         phase_reg     <= gpio_port_pkg::APB_IDLE;
      end else begin
         direction_reg <= direction_next;
         latch_reg     <= latch_next;
         analog_reg    <= analog_next;
         pullup_reg    <= pullup_next;
         pu_dis_reg    <= pu_dis_next;
         rdata_reg     <= rdata_next;
         err_reg       <= err_next;
         phase_reg     <= phase_next;
      end
   end

   assign prdata_o  = rdata_reg;
   assign pready_o  = 1'b1;
   assign pslverr_o = err_reg & access_ph;

   // ==========================================================
   // checks
   chk_drv_off_input: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE2] [RULE6] [RULE9]
      (pin_oe_n_o == (direction_reg | (8'h01 << `PORT_INPUT_ONLY_BIT))))
      else $error("driver enable does not follow direction");
   chk_pin_five_in: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE3]
      access_ph && !pwrite_i && paddr_i == `PORT_OFS_DIRECTION |-> prdata_o[`PORT_INPUT_ONLY_BIT])
      else $error("input-only pin direction read as output");
   chk_analog_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE8]
      $past(setup_ph && paddr_i == `PORT_OFS_PIN_LEVEL) && access_ph && !pwrite_i
      |-> (prdata_o[WIDTH-1:0] & $past(analog_reg)) == 8'h00)
      else $error("analog pin read nonzero");
   chk_pullup_output: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE13]
      (pullup_on_o & ~pin_oe_n_o) == 8'h00)
      else $error("pull-up on while driving");
   chk_pullup_reset: assert property (@(posedge ref_clk_i)  // [RULE14]
      $past(srst_i) |-> pullup_on_o == 8'h00)
      else $error("pull-up on after reset");
   chk_latch_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE15]
      access_ph && !pwrite_i && paddr_i == `PORT_OFS_LATCH |-> prdata_o[WIDTH-1:0] == $past(latch_reg))
      else $error("latch readback wrong");
   chk_port_rmw: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE5] [RULE10]
      wr_fire && pstrb_i[0] && paddr_i == `PORT_OFS_PIN_LEVEL
      |=> latch_reg == $past(pwdata_i[WIDTH-1:0] | digital_rd))
      else $error("port write did not merge into latch");
   chk_pin_value: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE4]
      pin_o == latch_reg)
      else $error("pin value differs from latch");
   // a latch write must show on the pin drive one edge later, not only in the register
   chk_latch_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE4] [RULE15]
      wr_fire && pstrb_i[0] && paddr_i == `PORT_OFS_LATCH |=> pin_o == $past(pwdata_i[WIDTH-1:0]))
      else $error("latch write did not reach pin drive");
   // port reads carry the filtered pins, never the latch
   chk_port_read_pins: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE4] [RULE8]
      $past(setup_ph && paddr_i == `PORT_OFS_PIN_LEVEL) && access_ph && !pwrite_i
      |-> prdata_o[WIDTH-1:0] == $past(level & ~analog_reg))
      else $error("port read does not show pin levels");
   // the input-only pin must never be driven, whatever software wrote
   chk_pin_five_drv: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE3]
      pin_oe_n_o[`PORT_INPUT_ONLY_BIT])
      else $error("input-only pin driven");
   // with the global disable off, every enabled input pin gets its pull-up
   chk_pullup_input: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE12] [RULE13]
      !pu_dis_reg |-> pullup_on_o == (pullup_reg & (direction_reg | (8'h01 << `PORT_INPUT_ONLY_BIT))))
      else $error("pull-up does not follow its enable");
endmodule : gpio_port

// *** src/gpio_port_params.svh ***
// constants for the 8-bit bidirectional pin port: register offsets, reset values, field positions
// assumes: included by bare name from design files; APB byte addresses, one 32-bit word per register
//
// Overview of operation
// RULE1: eight pins, each input or output
// RULE2: direction 1 disables driver, 0 drives latch
// RULE3: pin 5 input only, direction reads 1
// RULE4: port read gives pins, write hits latch
// RULE5: port write is read-modify-write into latch
// RULE6: direction controls drivers even for analog pins
// RULE7: software keeps analog pins set as inputs
// RULE8: analog-selected pin reads zero digitally
// RULE9: analog select leaves digital output untouched
// RULE10: read-modify-write may zero analog output latch
// RULE11: software initialises analog select for digital inputs
// RULE12: each pin has its own pull-up enable
// RULE13: pull-up off whenever pin is an output
// RULE14: global pull-up disable set after reset
// RULE15: output latch readable at its own offset
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ==========================================================
// register byte offsets
`define PORT_OFS_PIN_LEVEL   12'h000
`define PORT_OFS_DIRECTION   12'h004
`define PORT_OFS_LATCH       12'h008
`define PORT_OFS_ANALOG_SEL  12'h00C
`define PORT_OFS_PULLUP_EN   12'h010
`define PORT_OFS_OPTION      12'h014

// ==========================================================
// reset values and fields
`define PORT_RST_DIRECTION   8'hFF
`define PORT_RST_LATCH       8'h00
`define PORT_RST_ANALOG_SEL  8'hFF
`define PORT_RST_PULLUP_EN   8'hFF
`define PORT_RST_OPTION      1'h1
`define PORT_INPUT_ONLY_BIT  5
`define PORT_OPT_PU_DIS_BIT  7

`endif

// *** src/gpio_port_pkg.sv ***
// types shared by the pin port design
// assumes: compiled before every module that uses it
package gpio_port_pkg;
   // ==========================================================
   // apb slave handshake phase, one-hot
   typedef enum logic [1:0] {
      APB_IDLE   = 2'b01,  // waiting for setup
      APB_ACCESS = 2'b10   // access phase, answered now
   } apb_phase_t;
endpackage : gpio_port_pkg

// *** src/pin_input_sync.sv ***
// three-flop pin input synchroniser with agreement filter
// assumes: pin levels are asynchronous to ref_clk_i
`timescale 1ns/100ps
module pin_input_sync #(
   parameter int WIDTH = 8                  // number of pins
) (
   input  wire logic             ref_clk_i, // system clock
   input  wire logic             srst_i,    // sync reset, high
   input  wire logic [WIDTH-1:0] pin_i,     // raw pin levels
   output logic      [WIDTH-1:0] level_o    // filtered levels
);
   // ==========================================================
   // synchroniser chain
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_reg; // stages and held level
   logic [WIDTH-1:0] level_next;                       // next held level

   // a bit changes only once stages two and three agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
      end
   end

   // first stage is read only by the second
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         level_reg <= '0;
      end else begin
         s1_reg    <= pin_i;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign level_o = level_reg;
endmodule : pin_input_sync

// *** src/pin_pad_ctrl.sv ***
// per-pin pad control: driver enable, output value, pull-up, digital read gating
// assumes: purely combinational, fed from the register file
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module pin_pad_ctrl #(
   parameter int WIDTH = 8                      // number of pins
) (
   input  wire logic [WIDTH-1:0] direction_i,   // 1 = input
   input  wire logic [WIDTH-1:0] latch_i,       // output latch
   input  wire logic [WIDTH-1:0] analog_i,      // analog select
   input  wire logic [WIDTH-1:0] pullup_en_i,   // per-pin pull-up
   input  wire logic             pu_disable_i,  // global pull-up disable
   input  wire logic [WIDTH-1:0] level_i,       // synchronised pin levels
   output logic      [WIDTH-1:0] pad_out_o,     // pad output value
   output logic      [WIDTH-1:0] pad_oe_n_o,    // low = driving
   output logic      [WIDTH-1:0] pullup_on_o,   // weak pull-up active
   output logic      [WIDTH-1:0] digital_rd_o   // digital read value
);
   // ==========================================================
   // one slice per pin
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      if (i == `PORT_INPUT_ONLY_BIT) begin : g_in_only
         assign pad_oe_n_o[i] = 1'b1;                          // never driven [RULE3]
      end else begin : g_bidir
         // analog select plays no part here [RULE2] [RULE6] [RULE9]
         assign pad_oe_n_o[i] = direction_i[i];
      end
      assign pad_out_o[i]    = latch_i[i];                     // [RULE2]
      // pull-up only on inputs, gated globally [RULE12] [RULE13] [RULE14]
      assign pullup_on_o[i]  = pullup_en_i[i] & ~pu_disable_i & pad_oe_n_o[i];
      assign digital_rd_o[i] = level_i[i] & ~analog_i[i];     // analog reads zero [RULE8]
   end
endmodule : pin_pad_ctrl

// *** verif/pin_board.sv ***
// board model for the port pins: drivers, weak pull-ups, open lines
// assumes: bench sets the board drive; design pin outputs feed it
`timescale 1ns/100ps
module pin_board (
   input  wire logic       ref_clk_i,    // system clock
   input  wire logic [7:0] pin_o_i,      // design drive value
   input  wire logic [7:0] pin_oe_n_i,   // low = design drives
   input  wire logic [7:0] pullup_on_i,  // weak pull-up on
   input  wire logic [7:0] ext_en_i,     // board drives pin
   input  wire logic [7:0] ext_val_i,    // board drive value
   output logic      [7:0] level_o       // resolved pin level
);
   // ======================================
   // open lines alternate so a stale level never passes
   logic float_reg = 1'b0;  // alternating level, starts low
   logic float_next;        // its next value
   always_comb begin
      float_next = ~float_reg;
   end
   always_ff @(posedge ref_clk_i) begin
      float_reg <= float_next;
   end
   // ======================================
   // per pin: design driver, board driver, pull-up, else open
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n_i[i]) begin
            level_o[i] = pin_o_i[i];
         end else if (ext_en_i[i]) begin
            level_o[i] = ext_val_i[i];
         end else if (pullup_on_i[i]) begin
            level_o[i] = 1'b1;
         end else begin
            level_o[i] = float_reg;
         end
      end
   end
endmodule : pin_board

// *** verif/testbench.sv ***
// self-checking bench for the pin port over apb
// assumes: design files and the board model compiled first
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module testbench;
   logic        ref_clk_i;        // 200 MHz clock
   logic        srst_i;           // sync reset
   logic        psel;             // apb select
   logic        penable;          // apb enable
   logic        pwrite;           // apb direction
   logic [11:0] paddr;            // apb address
   logic [31:0] pwdata;           // apb write data
   logic [3:0]  pstrb;            // apb strobes
   logic [31:0] prdata;           // apb read data
   logic        pready;           // apb ready
   logic        pslverr;          // apb error
   logic [7:0]  pin_lvl;          // resolved pins
   logic [7:0]  pin_drv;          // design drive value
   logic [7:0]  pin_oe_n;         // low = driven
   logic [7:0]  pullup_on;        // pull-up state
   logic [7:0]  ext_en;           // board drive enable
   logic [7:0]  ext_val;          // board drive value
   int          num_errors = 0;   // mismatches
   int          cmp_count = 0;    // comparisons
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   gpio_port u_gpio_port (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pin_i(pin_lvl), .pin_o(pin_drv),
      .pin_oe_n_o(pin_oe_n), .pullup_on_o(pullup_on));
   pin_board u_pin_board (.ref_clk_i(ref_clk_i), .pin_o_i(pin_drv), .pin_oe_n_i(pin_oe_n),
      .pullup_on_i(pullup_on), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_lvl));
   // ======================================
   // closing report, the only exit
   task automatic end_sim();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk
   // ======================================
   // one apb transfer; waits for pready, bounded
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin  // wait ran out with no answer
         num_errors++;
         end_sim();
      end
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, {24'h000000, d}, q, e);
      @(posedge ref_clk_i);
   endtask : wr
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h00000000, q, e);
      chk(q, x, "read data");
      chk({31'h0, e}, {31'h0, xe}, "slave error");
   endtask : rd_chk
   task automatic pins_chk(input logic [7:0] drv, input logic [7:0] oen, input logic [7:0] pu);
      repeat (8) @(posedge ref_clk_i);  // pin sync settles in 4 edges
      chk({24'h0, pin_drv}, {24'h0, drv}, "pin drive");
      chk({24'h0, pin_oe_n}, {24'h0, oen}, "pin enable");
      chk({24'h0, pullup_on}, {24'h0, pu}, "pull-ups");
   endtask : pins_chk
   // ======================================
   // scenarios
   task automatic t_reset();
      pins_chk(8'h00, 8'hFF, 8'h00);
      rd_chk(`PORT_OFS_DIRECTION, 32'h000000FF, 1'b0);
      rd_chk(`PORT_OFS_LATCH, 32'h00000000, 1'b0);
      rd_chk(`PORT_OFS_ANALOG_SEL, 32'h000000FF, 1'b0);
      rd_chk(`PORT_OFS_PULLUP_EN, 32'h000000FF, 1'b0);
      rd_chk(`PORT_OFS_OPTION, 32'h00000080, 1'b0);
   endtask : t_reset
   task automatic t_output();
      wr(`PORT_OFS_ANALOG_SEL, 8'h00);
      wr(`PORT_OFS_DIRECTION, 8'h00);
      rd_chk(`PORT_OFS_DIRECTION, 32'h00000020, 1'b0);
      wr(`PORT_OFS_PIN_LEVEL, 8'h96);
      pins_chk(8'h96, 8'h20, 8'h00);
      rd_chk(`PORT_OFS_LATCH, 32'h00000096, 1'b0);
      ext_val <= 8'h20;                                     // board lifts the input-only pin
      repeat (8) @(posedge ref_clk_i);
      wr(`PORT_OFS_PIN_LEVEL, 8'h01);                       // pins read 0xB6, merged in
      rd_chk(`PORT_OFS_LATCH, 32'h000000B7, 1'b0);
      repeat (8) @(posedge ref_clk_i);
      rd_chk(`PORT_OFS_PIN_LEVEL, 32'h000000B7, 1'b0);
   endtask : t_output
   task automatic t_analog();
      wr(`PORT_OFS_ANALOG_SEL, 8'h0F);
      rd_chk(`PORT_OFS_PIN_LEVEL, 32'h000000B0, 1'b0);
      pins_chk(8'hB7, 8'h20, 8'h00);
      wr(`PORT_OFS_PIN_LEVEL, 8'h00);                       // analog bits read zero
      rd_chk(`PORT_OFS_LATCH, 32'h000000B0, 1'b0);
      ext_en <= 8'hFF;
      ext_val <= 8'h3C;
      wr(`PORT_OFS_DIRECTION, 8'hFF);
      pins_chk(8'hB0, 8'hFF, 8'h00);
      rd_chk(`PORT_OFS_PIN_LEVEL, 32'h00000030, 1'b0);
      rd_chk(`PORT_OFS_LATCH, 32'h000000B0, 1'b0);
   endtask : t_analog
   task automatic t_pullup();
      ext_en <= 8'h00;                                      // board lets go, lines open
      wr(`PORT_OFS_OPTION, 8'h00);
      wr(`PORT_OFS_PULLUP_EN, 8'h0F);
      wr(`PORT_OFS_DIRECTION, 8'h33);
      pins_chk(8'hB0, 8'h33, 8'h03);
      wr(`PORT_OFS_PULLUP_EN, 8'hFF);
      wr(`PORT_OFS_DIRECTION, 8'h00);
      pins_chk(8'hB0, 8'h20, 8'h20);
      wr(`PORT_OFS_OPTION, 8'h80);
      pins_chk(8'hB0, 8'h20, 8'h00);
   endtask : t_pullup
   task automatic t_refuse();
      wr(12'h018, 8'h55);
      rd_chk(12'h018, 32'h00000000, 1'b1);                  // unmapped word refused
      @(posedge ref_clk_i);
      pstrb <= 4'h0;
      wr(`PORT_OFS_LATCH, 8'h11);
      pstrb <= 4'hF;
      rd_chk(`PORT_OFS_LATCH, 32'h000000B0, 1'b0);
   endtask : t_refuse
   // ======================================
   // main sequence: reset 6 cycles, then scenarios
   initial begin
      srst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      ext_en = 8'h20;
      ext_val = 8'h00;
      repeat (6) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      t_reset();
      t_output();
      t_analog();
      t_pullup();
      t_refuse();
      end_sim();
   end
endmodule : testbench
